// ---- hdl/pmc_pkg.sv ----
/*
 * Shared constants and types for the power mode and clock control block.
 * Assumes a single synchronous clock domain; pin inputs are synchronised
 * in the top module before use.
 */
package pmc_pkg;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_FULL_ON,
    PMC_ACTIVE,
    PMC_SLEEP,
    PMC_DEEP_SLEEP
  } pmc_mode_e;

  // ****************************************************************
  // Widths and field layout
  // ****************************************************************
  localparam int PMC_MSEL_W = 5;   // Multiplier 1x to 31x
  localparam int PMC_SSEL_W = 2;   // Core to system ratio select
  localparam int PMC_NUM_PERIPH = 12;
  localparam int PMC_DIV_CNT_W = 3;

  // Peripheral clock enable bit positions
  localparam int PMC_PER_PCI = 0;
  localparam int PMC_PER_EBUS = 1;
  localparam int PMC_PER_FLAGS = 2;
  localparam int PMC_PER_MEMDMA = 3;
  localparam int PMC_PER_SPORT0 = 4;
  localparam int PMC_PER_SPORT1 = 5;
  localparam int PMC_PER_SPI0 = 6;
  localparam int PMC_PER_SPI1 = 7;
  localparam int PMC_PER_UART0 = 8;
  localparam int PMC_PER_UART1 = 9;
  localparam int PMC_PER_TIMERS = 10;
  localparam int PMC_PER_USB = 11;

  // ****************************************************************
  // Ratio encodings and reset values
  // ****************************************************************
  localparam logic [1:0] PMC_SSEL_2_0 = 2'h0;
  localparam logic [1:0] PMC_SSEL_2_5 = 2'h1;
  localparam logic [1:0] PMC_SSEL_3_0 = 2'h2;
  localparam logic [1:0] PMC_SSEL_4_0 = 2'h3;

  // Period lengths in core ticks; 2.5 alternates short and long
  localparam logic [2:0] PMC_LEN_2 = 3'h2;
  localparam logic [2:0] PMC_LEN_3 = 3'h3;
  localparam logic [2:0] PMC_LEN_4 = 3'h4;

  localparam logic [4:0] PMC_MSEL_MIN = 5'h01;
  localparam logic [11:0] PMC_IOCK_RST = 12'hfff;
  localparam logic [4:0] PMC_MSEL_RST = 5'h01;
  localparam logic [1:0] PMC_SSEL_RST = 2'h0;

endpackage

// ---- hdl/pmc_sysclk_div.sv ----
/*
 * System clock divider: turns core-rate ticks into a system clock level
 * and a one-cycle system tick per period.
 * Assumes base_tick comes from logic on the same clock.
 */
`timescale 1ns/1ps

module pmc_sysclk_div
  import pmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic base_tick,
  input wire logic [pmc_pkg::PMC_SSEL_W-1:0] ratio_sel,
  output logic sys_tick_q,
  output logic sys_level_q
);

  logic [PMC_DIV_CNT_W-1:0] cnt_q;
  logic [PMC_DIV_CNT_W-1:0] len_q;
  logic alt_q;
  logic [PMC_DIV_CNT_W-1:0] len_d;
  logic wrap;

  // ****************************************************************
  // Period length for the next period
  // ****************************************************************
  // Ratio is only taken up at a wrap, so no period is ever shortened
  always_comb begin
    len_d = PMC_LEN_2;
    case (ratio_sel)
      PMC_SSEL_2_0: len_d = PMC_LEN_2;
      PMC_SSEL_2_5: len_d = alt_q ? PMC_LEN_3 : PMC_LEN_2;
      PMC_SSEL_3_0: len_d = PMC_LEN_3;
      default: len_d = PMC_LEN_4;
    endcase
  end

  assign wrap = base_tick && (cnt_q == len_q - 3'h1);

  // Counter and length reload on clean boundaries
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      len_q <= PMC_LEN_2;
      alt_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= '0;
      len_q <= len_d;
      alt_q <= (ratio_sel == PMC_SSEL_2_5) ? ~alt_q : 1'b0;
    end else if (base_tick) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Level high for the first half of each period, rounded down
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sys_tick_q <= 1'b0;
      sys_level_q <= 1'b0;
    end else begin
      sys_tick_q <= wrap;
      if (wrap) begin
        sys_level_q <= 1'b1;
      end else if (base_tick) begin
        sys_level_q <= ((cnt_q + 3'h1) < (len_q >> 1));
      end
    end
  end

endmodule // pmc_sysclk_div

// ---- hdl/pmc_top.sv ----
/*
 * Power mode and clock control: mode state machine, core and system
 * clock ticks, peripheral clock gating and strap capture.
 * Assumes mclk is the multiplied PLL output; ref_clock_in, interrupt and
 * strap pins are asynchronous; software strobes are synchronous to mclk.
 */
`timescale 1ns/1ps

module pmc_top
  import pmc_pkg::*;
#(
  parameter int NUM_PERIPH = pmc_pkg::PMC_NUM_PERIPH
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ref_clock_in,
  input wire logic wake_irq,
  input wire logic rtc_irq,
  input wire logic [pmc_pkg::PMC_MSEL_W-1:0] multiplier_select_pins,
  input wire logic pll_bypass_pin,
  input wire logic divide_frequency_pin,
  input wire logic [pmc_pkg::PMC_SSEL_W-1:0] sysclk_select_pins,
  input wire logic ctl_wr,
  input wire logic [pmc_pkg::PMC_MSEL_W-1:0] ctl_msel,
  input wire logic ctl_bypass,
  input wire logic ctl_div_freq,
  input wire logic [pmc_pkg::PMC_SSEL_W-1:0] ctl_ssel,
  input wire logic iock_wr,
  input wire logic [NUM_PERIPH-1:0] iock_data,
  input wire logic mode_req,
  input wire pmc_pkg::pmc_mode_e mode_req_sel,
  input wire logic core_idle,
  output pmc_pkg::pmc_mode_e mode_q,
  output logic core_clock_q,
  output logic system_clock_output_pin,
  output logic [NUM_PERIPH-1:0] periph_clk_q,
  output logic deep_sleep_indicator_q,
  output logic pll_enable_q,
  output logic pll_bypass_q,
  output logic pll_div_freq_q,
  output logic [pmc_pkg::PMC_MSEL_W-1:0] pll_mult_q,
  output logic [pmc_pkg::PMC_SSEL_W-1:0] sysclk_divider_select_q,
  output logic l1_dma_allow_q,
  output logic async_access_allow_q,
  output logic [NUM_PERIPH-1:0] periph_clock_enable_q
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic wake_s1_q, wake_s2_q;
  logic rtc_s1_q, rtc_s2_q;
  logic [PMC_MSEL_W-1:0] strap_mult_s1_q, strap_mult_s2_q;
  logic [PMC_SSEL_W-1:0] strap_ratio_s1_q, strap_ratio_s2_q;
  logic strap_byp_s1_q, strap_byp_s2_q;
  logic strap_divf_s1_q, strap_divf_s2_q;
  logic strap_done_q;
  logic half_q;
  logic ref_rise;
  logic base_tick;
  logic sys_tick;
  logic sys_level;
  logic pll_bypass_bit_q;
  pmc_mode_e mode_d;

  // Reset asserts at once and releases two clocks later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pin inputs pass two flops; only the second stage is read, except ref, whose third flop feeds its edge detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      rtc_s1_q <= 1'b0;
      rtc_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      wake_s1_q <= wake_irq;
      wake_s2_q <= wake_s1_q;
      rtc_s1_q <= rtc_irq;
      rtc_s2_q <= rtc_s1_q;
    end
  end

  // Strap pairs carry no reset, so they are already full when reset lifts
  always_ff @(posedge mclk) begin
    strap_mult_s1_q <= multiplier_select_pins;
    strap_mult_s2_q <= strap_mult_s1_q;
    strap_ratio_s1_q <= sysclk_select_pins;
    strap_ratio_s2_q <= strap_ratio_s1_q;
    strap_byp_s1_q <= pll_bypass_pin;
    strap_byp_s2_q <= strap_byp_s1_q;
    strap_divf_s1_q <= divide_frequency_pin;
    strap_divf_s2_q <= strap_divf_s1_q;
  end

  assign ref_rise = ref_s2_q && !ref_s3_q;

  // ****************************************************************
  // PLL control register and straps
  // ****************************************************************
  // Straps are caught by the first clock after release, never by reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      pll_mult_q <= PMC_MSEL_RST;
      pll_bypass_bit_q <= 1'b0;
      pll_div_freq_q <= 1'b0;
      sysclk_divider_select_q <= PMC_SSEL_RST;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      // Zero would mean no multiply at all; clamp to 1x
      pll_mult_q <= (strap_mult_s2_q == '0) ? PMC_MSEL_MIN
                    : strap_mult_s2_q;
      pll_bypass_bit_q <= strap_byp_s2_q;
      pll_div_freq_q <= strap_divf_s2_q;
      sysclk_divider_select_q <= strap_ratio_s2_q;
    end else if (ctl_wr) begin
      // Multiplier only moves while the PLL is bypassed and unused
      if (mode_q == PMC_ACTIVE) begin
        pll_mult_q <= (ctl_msel == '0) ? PMC_MSEL_MIN : ctl_msel;
        pll_div_freq_q <= ctl_div_freq;
      end
      pll_bypass_bit_q <= ctl_bypass;
      sysclk_divider_select_q <= ctl_ssel;
    end
  end

  // Peripheral clock enable register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periph_clock_enable_q <= PMC_IOCK_RST[NUM_PERIPH-1:0];
    end else if (iock_wr) begin
      periph_clock_enable_q <= iock_data;
    end
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  // Reset itself is the deep sleep reset exit; the strap picks the mode
  always_comb begin
    mode_d = mode_q;
    if (!strap_done_q) begin
      mode_d = strap_byp_s2_q ? PMC_ACTIVE : PMC_FULL_ON;
    end else begin
      case (mode_q)
        PMC_SLEEP: begin
          if (wake_s2_q || rtc_s2_q) begin
            mode_d = pll_bypass_bit_q ? PMC_ACTIVE : PMC_FULL_ON;
          end
        end
        PMC_DEEP_SLEEP: begin
          // Ordinary interrupts are ignored here
          if (rtc_s2_q) begin
            mode_d = PMC_FULL_ON;
          end
        end
        default: begin
          if (mode_req && core_idle) begin
            mode_d = mode_req_sel;
          end
        end
      endcase
    end
  end

  // Mode changes only at strap capture, at a system period boundary or from deep sleep
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= PMC_FULL_ON;
    end else if (!strap_done_q || sys_tick || mode_q == PMC_DEEP_SLEEP) begin
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // Core tick generation
  // ****************************************************************
  // Half rate of the reference in bypass: one tick every second rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else if (ref_rise) begin
      half_q <= ~half_q;
    end
  end

  always_comb begin
    base_tick = 1'b0;
    case (mode_q)
      PMC_FULL_ON: base_tick = 1'b1;
      PMC_ACTIVE: base_tick = ref_rise && half_q;
      PMC_SLEEP: base_tick = pll_bypass_bit_q ? (ref_rise && half_q) : 1'b1;
      default: base_tick = 1'b0;
    endcase
  end

  pmc_sysclk_div u_div (
    .mclk(mclk),
    .rst_b(rst_n),
    .base_tick(base_tick),
    .ratio_sel(sysclk_divider_select_q),
    .sys_tick_q(sys_tick),
    .sys_level_q(sys_level)
  );

  // ****************************************************************
  // Clock and status outputs
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_clock_q <= 1'b0;
      system_clock_output_pin <= 1'b0;
      pll_enable_q <= 1'b1;
      pll_bypass_q <= 1'b0;
      deep_sleep_indicator_q <= 1'b0;
      l1_dma_allow_q <= 1'b0;
      async_access_allow_q <= 1'b0;
    end else begin
      // Core ticks are whole pulses, so gating never clips one
      core_clock_q <= base_tick && (mode_q == PMC_FULL_ON || mode_q == PMC_ACTIVE);
      system_clock_output_pin <= sys_level && (mode_q != PMC_DEEP_SLEEP);
      pll_enable_q <= (mode_q != PMC_DEEP_SLEEP);
      pll_bypass_q <= (mode_q == PMC_ACTIVE) ||
                      (mode_q == PMC_SLEEP && pll_bypass_bit_q);
      deep_sleep_indicator_q <= (mode_q == PMC_DEEP_SLEEP);
      l1_dma_allow_q <= (mode_q == PMC_FULL_ON || mode_q == PMC_ACTIVE);
      async_access_allow_q <= (mode_q != PMC_DEEP_SLEEP);
    end
  end

  // Peripheral clocks come from the system tick, one gate per unit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          periph_clk_q[gi] <= 1'b0;
        end else begin
          periph_clk_q[gi] <= sys_tick && periph_clock_enable_q[gi]
                              && (mode_q != PMC_DEEP_SLEEP);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  deep_indicator_a: assert property (
    (mode_q == PMC_DEEP_SLEEP) |=> deep_sleep_indicator_q)
    else $error("deep sleep indicator low in deep sleep");
  deep_ind_off_a: assert property (
    (strap_done_q && mode_q != PMC_DEEP_SLEEP) |=> !deep_sleep_indicator_q)
    else $error("deep sleep indicator high outside deep sleep");
  deep_stays_a: assert property (
    (mode_q == PMC_DEEP_SLEEP && !rtc_s2_q) |=> (mode_q == PMC_DEEP_SLEEP))
    else $error("deep sleep left without rtc interrupt");
  rtc_wake_a: assert property (
    (mode_q == PMC_DEEP_SLEEP && rtc_s2_q) |=> (mode_q == PMC_FULL_ON))
    else $error("rtc wake did not reach full on");
  sleep_core_a: assert property (
    (mode_q == PMC_SLEEP) ##1 (mode_q == PMC_SLEEP) |-> !core_clock_q)
    else $error("core clock running in sleep");
  deep_clocks_a: assert property (
    $past(mode_q == PMC_DEEP_SLEEP) |-> (!system_clock_output_pin && !pll_enable_q
                                          && periph_clk_q == '0))
    else $error("clocks or pll active in deep sleep");
  full_core_a: assert property (
    (strap_done_q && mode_q == PMC_FULL_ON) [*2] |-> (core_clock_q && !pll_bypass_q))
    else $error("full on core clock not every cycle");
  sleep_dma_a: assert property (
    $past(mode_q == PMC_SLEEP) |-> !l1_dma_allow_q)
    else $error("dma allowed in sleep");
  idle_gate_a: assert property (
    (strap_done_q && mode_q inside {PMC_FULL_ON, PMC_ACTIVE} && !core_idle)
    |=> (mode_q == $past(mode_q)))
    else $error("mode changed without idle core");
  mode_idle_a: assert property (
    (strap_done_q && $past(strap_done_q) && $past(mode_q) inside {PMC_FULL_ON, PMC_ACTIVE}
     && mode_q != $past(mode_q)) |-> $past(mode_req && core_idle))
    else $error("mode changed without idle request");
  periph_gate_a: assert property (
    (!periph_clock_enable_q[0]) |=> !periph_clk_q[0])
    else $error("disabled peripheral clock ticked");

  sleep_wake_c: cover property ((mode_q == PMC_SLEEP) ##1 (mode_q == PMC_ACTIVE));
  deep_rtc_c: cover property ((mode_q == PMC_DEEP_SLEEP) ##1 (mode_q == PMC_FULL_ON));
  ratio_25_c: cover property ((sysclk_divider_select_q == PMC_SSEL_2_5) && sys_tick);
  mult_wr_c: cover property (ctl_wr && mode_q == PMC_ACTIVE);

endmodule // pmc_top

// ---- testbench/pmc_src_model.sv ----
/*
 * Far-side model: the free-running reference clock source and the two
 * wake interrupt sources (any interrupt, real-time clock interrupt).
 * Assumes the bench changes the commands just after an mclk edge.
 */
`timescale 1ns/1ps

module pmc_src_model #(
  parameter int REF_HALF_NS = 160
)
(
  input wire logic wake_cmd,
  input wire logic rtc_cmd,
  output logic ref_clock_in,
  output logic wake_irq,
  output logic rtc_irq
);
  // ****************************************************************
  // Reference clock
  // ****************************************************************
  // Never halted; the odd start offset keeps it out of phase with mclk
  initial begin
    ref_clock_in = 1'b0;
    #7;
    forever #(REF_HALF_NS) ref_clock_in = ~ref_clock_in;
  end

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  // Level interrupts, held as long as the source asks for service
  assign wake_irq = wake_cmd;
  assign rtc_irq = rtc_cmd;
endmodule // pmc_src_model

// ---- testbench/power_mode_clock_control_bench.sv ----
/*
 * Self-checking bench for pmc_top: strap capture, divider ratios,
 * peripheral gating and every mode transition except active to sleep.
 * Assumes pmc_pkg is compiled first and pmc_src_model is available.
 */
`timescale 1ns/1ps

module power_mode_clock_control_bench;
  import pmc_pkg::*;

  // ****************************************************************
  // Signals, clock and instances
  // ****************************************************************
  logic mclk = 1'b0, rst_b = 1'b0, ctl_wr = 1'b0, ctl_bypass = 1'b0, ctl_div_freq = 1'b0;
  logic pll_bypass_pin = 1'b0, divide_frequency_pin = 1'b1, iock_wr = 1'b0;
  logic mode_req = 1'b0, core_idle = 1'b0, wake_cmd = 1'b0, rtc_cmd = 1'b0;
  logic [4:0] multiplier_select_pins = 5'h06, ctl_msel = 5'h00;
  logic [1:0] sysclk_select_pins = 2'h2, ctl_ssel = 2'h0;
  logic [11:0] iock_data = 12'h000, per_seen, periph_clk_q, periph_clock_enable_q;
  pmc_mode_e mode_req_sel = PMC_FULL_ON, mode_q;
  logic ref_clock_in, wake_irq, rtc_irq, core_clock_q, system_clock_output_pin;
  logic deep_sleep_indicator_q, pll_enable_q, pll_bypass_q, pll_div_freq_q;
  logic l1_dma_allow_q, async_access_allow_q;
  logic [4:0] pll_mult_q;
  logic [1:0] sysclk_divider_select_q;
  int fails = 0, checks = 0, core_n, rise_n, p1, p2;

  // 25 MHz master clock
  always #20 mclk = ~mclk;

  pmc_src_model #(.REF_HALF_NS(160)) src (.wake_cmd(wake_cmd), .rtc_cmd(rtc_cmd),
    .ref_clock_in(ref_clock_in), .wake_irq(wake_irq), .rtc_irq(rtc_irq));

  pmc_top uut (.mclk(mclk), .rst_b(rst_b), .ref_clock_in(ref_clock_in),
    .wake_irq(wake_irq), .rtc_irq(rtc_irq), .multiplier_select_pins(multiplier_select_pins),
    .pll_bypass_pin(pll_bypass_pin), .divide_frequency_pin(divide_frequency_pin),
    .sysclk_select_pins(sysclk_select_pins), .ctl_wr(ctl_wr), .ctl_msel(ctl_msel),
    .ctl_bypass(ctl_bypass), .ctl_div_freq(ctl_div_freq), .ctl_ssel(ctl_ssel),
    .iock_wr(iock_wr),
    .iock_data(iock_data), .mode_req(mode_req), .mode_req_sel(mode_req_sel),
    .core_idle(core_idle), .mode_q(mode_q), .core_clock_q(core_clock_q),
    .system_clock_output_pin(system_clock_output_pin), .periph_clk_q(periph_clk_q),
    .deep_sleep_indicator_q(deep_sleep_indicator_q), .pll_enable_q(pll_enable_q),
    .pll_bypass_q(pll_bypass_q), .pll_div_freq_q(pll_div_freq_q), .pll_mult_q(pll_mult_q),
    .sysclk_divider_select_q(sysclk_divider_select_q), .l1_dma_allow_q(l1_dma_allow_q),
    .async_access_allow_q(async_access_allow_q),
    .periph_clock_enable_q(periph_clock_enable_q));

  // ****************************************************************
  // Access and checking tasks
  // ****************************************************************
  // Sample 1 ns after each edge so design updates have landed
  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic do_reset(input logic byp);
    @(posedge mclk) rst_b <= 1'b0;
    pll_bypass_pin <= byp;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) step();
  endtask

  task automatic wr_ctl(input logic [4:0] m, input logic b, input logic [1:0] s);
    @(posedge mclk) ctl_wr <= 1'b1;
    ctl_msel <= m;
    ctl_bypass <= b;
    ctl_div_freq <= 1'b0;
    ctl_ssel <= s;
    @(posedge mclk) ctl_wr <= 1'b0;
    step();
  endtask

  // Waits a bounded number of cycles for the mode to become m
  task automatic wait_mode(input pmc_mode_e m, input int lim, input string msg);
    int n;
    n = 0;
    while (mode_q !== m && n < lim) begin
      step();
      n++;
    end
    chk(mode_q, m, msg);
  endtask

  // Programmed change: held until the mode moves, core idle with irqs off
  task automatic req_mode(input pmc_mode_e m);
    @(posedge mclk) mode_req <= 1'b1;
    mode_req_sel <= m;
    core_idle <= 1'b1;
    wait_mode(m, 150, "programmed mode change");
    @(posedge mclk) mode_req <= 1'b0;
    core_idle <= 1'b0;
    repeat (2) step();
  endtask

  // Counts core ticks and system clock rises over n cycles, and records which peripherals tick
  task automatic watch(input int n);
    logic prev;
    core_n = 0;
    rise_n = 0;
    per_seen = '0;
    repeat (n) begin
      prev = system_clock_output_pin;
      step();
      if (core_clock_q === 1'b1) core_n++;
      if (prev === 1'b0 && system_clock_output_pin === 1'b1) rise_n++;
      per_seen = per_seen | periph_clk_q;
    end
  endtask

  // Cycles until the next system clock rise, bounded
  task automatic next_rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = system_clock_output_pin;
      step();
      n++;
    end while (!(prev === 1'b0 && system_clock_output_pin === 1'b1) && n < 50);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    do_reset(1'b0);
    chk(mode_q, PMC_FULL_ON, "reset mode");
    chk(pll_mult_q, 5'h06, "strapped multiplier");
    chk(sysclk_divider_select_q, 2'h2, "strapped divider");
    chk({pll_enable_q, pll_bypass_q, pll_div_freq_q}, 3'b101, "pll after reset");
    chk(periph_clock_enable_q, PMC_IOCK_RST, "enable reset");
    wr_ctl(5'h1f, 1'b0, 2'h2);
    chk(pll_mult_q, 5'h06, "multiplier write outside active");
    watch(20);
    chk(core_n, 20, "full on core ticks");
    $display("test reset_and_full_on done");

    // Each ratio: align on two rises, then time two periods
    // Every ratio keeps the system clock within its rating at this mclk
    for (int s = 0; s < 4; s++) begin
      wr_ctl(5'h00, 1'b0, s[1:0]);
      chk(sysclk_divider_select_q, s, "divider write");
      next_rise(p1);
      next_rise(p1);
      next_rise(p1);
      next_rise(p2);
      if (s == 1) begin
        chk(p1 + p2, 5, "2.5 ratio pair");
        chk(p1 != p2, 1, "2.5 alternation");
      end else begin
        chk(p1, (s == 0) ? 2 : s + 1, "ratio period");
        chk(p2, p1, "ratio steady");
      end
    end
    $display("test divider_ratios done");

    @(posedge mclk) iock_wr <= 1'b1;
    iock_data <= 12'h5a2;
    @(posedge mclk) iock_wr <= 1'b0;
    watch(40);
    chk(periph_clock_enable_q, 12'h5a2, "enable readback");
    chk(per_seen, 12'h5a2, "only enabled peripherals tick");
    $display("test peripheral_gating done");

    // Without an idle core the request must wait
    @(posedge mclk) mode_req <= 1'b1;
    mode_req_sel <= PMC_ACTIVE;
    repeat (30) step();
    chk(mode_q, PMC_FULL_ON, "request without idle");
    req_mode(PMC_ACTIVE);
    chk({pll_enable_q, pll_bypass_q, l1_dma_allow_q}, 3'b111, "active state");
    watch(160);
    chk(core_n >= 9 && core_n <= 11, 1, "core at half reference");
    wr_ctl(5'h0a, 1'b0, 2'h3);
    chk(pll_mult_q, 5'h0a, "multiplier write in active");
    wr_ctl(5'h00, 1'b0, 2'h3);
    chk(pll_mult_q, 5'h01, "zero multiplier clamps");
    req_mode(PMC_FULL_ON);
    $display("test active_mode done");

    // Bench keeps DMA idle around every transition
    req_mode(PMC_SLEEP);
    watch(30);
    chk(core_n, 0, "sleep core gated");
    chk(rise_n > 0, 1, "sleep system clock runs");
    chk({pll_enable_q, l1_dma_allow_q}, 2'b10, "sleep pll and dma");
    @(posedge mclk) wake_cmd <= 1'b1;
    wait_mode(PMC_FULL_ON, 20, "sleep wake bypass clear");
    @(posedge mclk) wake_cmd <= 1'b0;
    wr_ctl(5'h00, 1'b1, 2'h3);
    req_mode(PMC_SLEEP);
    @(posedge mclk) rtc_cmd <= 1'b1;
    wait_mode(PMC_ACTIVE, 100, "sleep wake bypass set");
    @(posedge mclk) rtc_cmd <= 1'b0;
    $display("test sleep_mode done");

    req_mode(PMC_DEEP_SLEEP);
    @(posedge mclk) wake_cmd <= 1'b1;
    watch(30);
    chk(mode_q, PMC_DEEP_SLEEP, "deep ignores other irq");
    chk(deep_sleep_indicator_q, 1'b1, "deep indicator");
    chk({pll_enable_q, async_access_allow_q, l1_dma_allow_q}, 3'b000, "deep gating");
    chk(core_n + rise_n + per_seen, 0, "deep clocks stopped");
    @(posedge mclk) wake_cmd <= 1'b0;
    rtc_cmd <= 1'b1;
    wait_mode(PMC_FULL_ON, 6, "rtc wake from deep");
    @(posedge mclk) rtc_cmd <= 1'b0;
    step();
    chk(deep_sleep_indicator_q, 1'b0, "indicator cleared");
    req_mode(PMC_DEEP_SLEEP);
    do_reset(1'b1);
    chk(mode_q, PMC_ACTIVE, "reset from deep with bypass pin");
    $display("test deep_sleep done");
    finish_test();
  end

  // Whole sequence needs under a thousand cycles; cut a hang well beyond
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // power_mode_clock_control_bench
